// [hw/tam_mission_cfg.sv]
// mission configuration registers, alarm qualification and log sequencing
// Operation
// - result codes mean upper/2 minus 41 plus lower/512 degrees in wide format
// - threshold byte is twice the limit plus 82, half degree steps
// - low threshold byte at 0208h, high threshold byte at 0209h
// - alarms compare only the upper result byte in either format
// - alarm raised only when value alarming and its enable bit set
// - high enable set: conversion at or above high threshold sets high flag
// - low enable set: conversion at or below low threshold sets low flag
// - alarm enable bits 7:2 read zero; register locked during mission
// - low and high alarm flags reported in status at 0214h
// - rate unit bit selects minutes when 0, seconds when 1
// - oscillator enable runs clock; zero stops it into retention state
// - start mission command forces oscillator enable to one
// - enabling oscillator in memory-cleared state adds extra start-up delay
// - clock control bits 7:2 read zero; register locked during mission
// - mission control bits 7,6,4 read one; locked during mission
// - without start on alarm, mission runs right after start delay
// - start on alarm: 8-bit conversions, logging begins with alarming sample
// - triggering alarm sample does not advance mission sample counter
// - format bit picks one or two bytes, upper byte at lower address
// - logging only with logging enable set, starting at 1000h
// - out of range reads 00h/0000h when cold, FFh/FFE0h when hot
`timescale 1ns/1ps
module tam_mission_cfg #(
    parameter int OSC_STARTUP_US = tam_pkg::OSC_STARTUP_US,
    parameter int LOG_AW         = 17
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire tam_pkg::tam_regreq_s regReq,
    input  wire tam_pkg::tam_conv_s   conv,
    input  wire logic                startMissionCmd,
    input  wire logic                stopMissionCmd,
    input  wire logic                clearMemoryCmd,
    input  wire logic                startDelayDone,
    output logic [7:0]               regRdata,
    output tam_pkg::tam_logwr_s      logWr,
    output logic                     sampleTick,
    output logic                     missionRunning,
    output logic                     oscillatorEnable,
    output logic                     oscRunning,
    output logic                     rateUnitSeconds
);
    import tam_pkg::*;
    localparam int OSC_CYC = (OSC_STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [16:0] LOG_LAST = 17'((1 << LOG_AW) - 1);
    // refuse sizes the logic cannot serve
    if (LOG_AW != 17 || OSC_STARTUP_US < 1) begin : g_bad_param
        $error("LOG_AW must be 17 and OSC_STARTUP_US positive");
    end
    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rstSync_r;
    logic       rstN;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_r <= 2'h0;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstN = rstSync_r[1];
    // conversion code with out-of-range saturation
    function automatic logic [15:0] codeOf(input tam_conv_s c);
        codeOf = c.under ? CODE_UNDER : (c.over ? CODE_OVER : {c.raw, RAW_SHIFT'(0)});
    endfunction
    // write hit on one register address
    function automatic logic wrHit(input tam_regreq_s r, input logic [15:0] a);
        wrHit = r.wr && (r.addr == a);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]  lowThr_r, lowThr_nxt, highThr_r, highThr_nxt;
    logic [1:0]  alarmEn_r, alarmEn_nxt, clkCtl_r, clkCtl_nxt;
    logic        startOnAlarm_r, startOnAlarm_nxt, misX3_r, misX3_nxt;
    logic        logWide_r, logWide_nxt, misB1_r, misB1_nxt, logEn_r, logEn_nxt;
    logic        highFlag_r, highFlag_nxt, lowFlag_r, lowFlag_nxt;
    logic        borFlag_r, borFlag_nxt, memClr_r, memClr_nxt;
    logic        waitAlarm_r, waitAlarm_nxt;
    logic [15:0] latest_r, latest_nxt;
    logic [31:0] oscCnt_r, oscCnt_nxt;
    logic        oscReady_r, oscReady_nxt;
    tam_mis_e    mis_r, mis_nxt;
    logic [16:0] logPtr_r, logPtr_nxt;
    logic        lowPend_r, lowPend_nxt;
    logic [7:0]  lowByte_r, lowByte_nxt;
    tam_logwr_s  logWr_r, logWr_nxt;
    logic        tick_r, tick_nxt, running_r, running_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic [15:0] code;
    logic        highHit, lowHit, locked, startOk, logEvent, inMission;
    // comparator on the upper byte of the incoming conversion
    tam_alarm_cmp u_cmp (
        .upperByte (code[15:8]),
        .lowThr    (lowThr_r),
        .highThr   (highThr_r),
        .highEn    (alarmEn_r[BIT_HIGH_EN]),
        .lowEn     (alarmEn_r[BIT_LOW_EN]),
        .highHit   (highHit),
        .lowHit    (lowHit)
    );
    assign code      = codeOf(conv);
    assign locked    = (mis_r != MS_IDLE);
    assign startOk   = startMissionCmd && !locked && memClr_r;
    assign inMission = (mis_r == MS_WAIT) || (mis_r == MS_RUN);
    ////////////////////////////////////////////////////////////////////////
    // configuration registers, flags and oscillator start-up
    always_comb begin
        lowThr_nxt       = lowThr_r;
        highThr_nxt      = highThr_r;
        alarmEn_nxt      = alarmEn_r;
        clkCtl_nxt       = clkCtl_r;
        startOnAlarm_nxt = startOnAlarm_r;
        misX3_nxt        = misX3_r;
        logWide_nxt      = logWide_r;
        misB1_nxt        = misB1_r;
        logEn_nxt        = logEn_r;
        highFlag_nxt     = highFlag_r;
        lowFlag_nxt      = lowFlag_r;
        borFlag_nxt      = borFlag_r;
        memClr_nxt       = memClr_r;
        latest_nxt       = latest_r;
        oscCnt_nxt       = oscCnt_r;
        oscReady_nxt     = oscReady_r;
        // threshold bytes, host codes them as twice the limit plus offset
        if (wrHit(regReq, ADR_LOW_THR)) begin
            lowThr_nxt = regReq.wdata;
        end
        if (wrHit(regReq, ADR_HIGH_THR)) begin
            highThr_nxt = regReq.wdata;
        end
        // control registers accept writes only between missions
        if (wrHit(regReq, ADR_ALM_EN) && !locked) begin
            alarmEn_nxt = regReq.wdata[1:0];
        end
        if (wrHit(regReq, ADR_CLK_CTL) && !locked) begin
            clkCtl_nxt = regReq.wdata[1:0];
        end
        if (wrHit(regReq, ADR_MIS_CTL) && !locked) begin
            startOnAlarm_nxt = regReq.wdata[BIT_START_ALM];
            misX3_nxt        = regReq.wdata[BIT_MIS_X3];
            logWide_nxt      = regReq.wdata[BIT_WIDE];
            misB1_nxt        = regReq.wdata[BIT_MIS_B1];
            logEn_nxt        = regReq.wdata[BIT_LOG_EN];
        end
        if (startOk) begin
            clkCtl_nxt[BIT_OSC_EN] = 1'b1;
            memClr_nxt             = 1'b0;
        end
        if (clearMemoryCmd && !locked) begin // clearing memory drops every alarm bit
            highFlag_nxt = 1'b0;
            lowFlag_nxt  = 1'b0;
            borFlag_nxt  = 1'b0;
            memClr_nxt   = 1'b1;
        end
        // mission conversions; a hit wins over a same-cycle clear
        if (conv.valid && inMission) begin
            latest_nxt = code;
            if (highHit) begin
                highFlag_nxt = 1'b1;
            end
            if (lowHit) begin
                lowFlag_nxt = 1'b1;
            end
        end
        if (!clkCtl_nxt[BIT_OSC_EN]) begin // extra start-up wait only out of the memory-cleared state
            oscCnt_nxt   = 32'h0;
            oscReady_nxt = 1'b0;
        end else if (!clkCtl_r[BIT_OSC_EN]) begin
            oscCnt_nxt   = memClr_r ? 32'(OSC_CYC - 1) : 32'h0;
            oscReady_nxt = 1'b0;
        end else if (oscCnt_r != 32'h0) begin
            oscCnt_nxt = oscCnt_r - 32'h1;
        end else begin
            oscReady_nxt = 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // mission sequencing and data log writer
    always_comb begin
        mis_nxt       = mis_r;
        waitAlarm_nxt = waitAlarm_r;
        logPtr_nxt    = logPtr_r;
        lowPend_nxt   = 1'b0;
        lowByte_nxt   = lowByte_r;
        logWr_nxt     = '0;
        tick_nxt      = 1'b0;
        logEvent      = 1'b0;
        case (mis_r)
            MS_IDLE: begin
                if (startOk) begin
                    mis_nxt       = MS_DELAY;
                    logPtr_nxt    = LOG_BASE;
                    waitAlarm_nxt = startOnAlarm_r;
                end
            end
            MS_DELAY: begin
                if (startDelayDone) begin
                    mis_nxt = startOnAlarm_r ? MS_WAIT : MS_RUN;
                end
            end
            MS_WAIT: begin
                if (conv.valid && (highHit || lowHit)) begin // alarming sample opens the log, uncounted
                    mis_nxt       = MS_RUN;
                    waitAlarm_nxt = 1'b0;
                    logEvent      = 1'b1;
                end
            end
            MS_RUN: begin
                if (conv.valid) begin
                    logEvent = 1'b1;
                    tick_nxt = 1'b1;
                end
            end
            default: begin
                mis_nxt = MS_IDLE;
            end
        endcase
        if (stopMissionCmd && locked) begin
            mis_nxt = MS_IDLE;
        end
        running_nxt = (mis_nxt != MS_IDLE); // registered copy of the mission state for the output
        if (lowPend_r) begin // pending lower byte goes to the next address
            logWr_nxt = '{we: 1'b1, addr: logPtr_r, data: lowByte_r};
            if (logPtr_r != LOG_LAST) begin
                logPtr_nxt = logPtr_r + 17'h1;
            end
        end else if (logEvent && logEn_r && (logPtr_r != LOG_LAST)) begin
            logWr_nxt  = '{we: 1'b1, addr: logPtr_r, data: code[15:8]};
            logPtr_nxt = logPtr_r + 17'h1;
            lowByte_nxt = (mis_r == MS_WAIT) ? 8'h00 : code[7:0]; // trigger sample is 8-bit, lower byte zero
            lowPend_nxt = logWide_r;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the address
    always_comb begin
        case (regReq.addr)
            ADR_LOW_THR:  rdata_nxt = lowThr_r;
            ADR_HIGH_THR: rdata_nxt = highThr_r;
            ADR_RES_LO:   rdata_nxt = latest_r[7:0];
            ADR_RES_HI:   rdata_nxt = latest_r[15:8];
            ADR_ALM_EN:   rdata_nxt = {6'h00, alarmEn_r};
            ADR_CLK_CTL:  rdata_nxt = {6'h00, clkCtl_r};
            ADR_MIS_CTL:  rdata_nxt = {2'h3, startOnAlarm_r, 1'b1, misX3_r, logWide_r, misB1_r, logEn_r};
            ADR_ALM_STAT: rdata_nxt = {borFlag_r, 3'h7, 2'h0, highFlag_r, lowFlag_r};
            ADR_GEN_STAT: rdata_nxt = {3'h6, waitAlarm_r, memClr_r, 1'b0, locked, 1'b0};
            default:      rdata_nxt = 8'h00;
        endcase
    end
    // all state registers
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            lowThr_r       <= RST_THR;
            highThr_r      <= RST_THR;
            alarmEn_r      <= RST_CTL2;
            clkCtl_r       <= RST_CTL2;
            startOnAlarm_r <= 1'b0;
            misX3_r        <= 1'b0;
            logWide_r      <= 1'b0;
            misB1_r        <= 1'b0;
            logEn_r        <= 1'b0;
            highFlag_r     <= 1'b0;
            lowFlag_r      <= 1'b0;
            borFlag_r      <= 1'b1;
            memClr_r       <= 1'b0;
            waitAlarm_r    <= 1'b0;
            latest_r       <= 16'h0000;
            oscCnt_r       <= 32'h0;
            oscReady_r     <= 1'b0;
            mis_r          <= MS_IDLE;
            logPtr_r       <= LOG_BASE;
            lowPend_r      <= 1'b0;
            lowByte_r      <= 8'h00;
            logWr_r        <= '0;
            tick_r         <= 1'b0;
            running_r      <= 1'b0;
            rdata_r        <= 8'h00;
        end else begin
            lowThr_r       <= lowThr_nxt;
            highThr_r      <= highThr_nxt;
            alarmEn_r      <= alarmEn_nxt;
            clkCtl_r       <= clkCtl_nxt;
            startOnAlarm_r <= startOnAlarm_nxt;
            misX3_r        <= misX3_nxt;
            logWide_r      <= logWide_nxt;
            misB1_r        <= misB1_nxt;
            logEn_r        <= logEn_nxt;
            highFlag_r     <= highFlag_nxt;
            lowFlag_r      <= lowFlag_nxt;
            borFlag_r      <= borFlag_nxt;
            memClr_r       <= memClr_nxt;
            waitAlarm_r    <= waitAlarm_nxt;
            latest_r       <= latest_nxt;
            oscCnt_r       <= oscCnt_nxt;
            oscReady_r     <= oscReady_nxt;
            mis_r          <= mis_nxt;
            logPtr_r       <= logPtr_nxt;
            lowPend_r      <= lowPend_nxt;
            lowByte_r      <= lowByte_nxt;
            logWr_r        <= logWr_nxt;
            tick_r         <= tick_nxt;
            running_r      <= running_nxt;
            rdata_r        <= rdata_nxt;
        end
    end
    // outputs straight from flops
    assign regRdata         = rdata_r;
    assign logWr            = logWr_r;
    assign sampleTick       = tick_r;
    assign missionRunning   = running_r;
    assign oscillatorEnable = clkCtl_r[BIT_OSC_EN];
    assign oscRunning       = oscReady_r;
    assign rateUnitSeconds  = clkCtl_r[BIT_RATE_SEC];
    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);
    sequence s_hiconv;
        conv.valid && inMission && highHit;
    endsequence
    sequence s_trigger;
        conv.valid && (mis_r == MS_WAIT) && (highHit || lowHit);
    endsequence
    a_high_flag_set: assert property (s_hiconv |=> highFlag_r) else $error("high flag not set");
    a_low_flag_set: assert property (conv.valid && inMission && lowHit |=> lowFlag_r) else $error("low flag missed");
    a_flag_needs_en: assert property ($rose(highFlag_r) |-> $past(alarmEn_r[BIT_HIGH_EN])) else $error("high flag w/o enable");
    a_en_lock_hold: assert property (locked && wrHit(regReq, ADR_ALM_EN) |=> $stable(alarmEn_r)) else $error("enable written in mission");
    a_en_read_zero: assert property (regReq.addr == ADR_ALM_EN |=> regRdata[7:2] == 6'h00) else $error("enable reserved bits");
    a_mis_ones: assert property (regReq.addr == ADR_MIS_CTL |=> regRdata[7:6] == 2'h3 && regRdata[4]) else $error("mission ones");
    a_start_osc_on: assert property (startOk |=> oscillatorEnable && missionRunning) else $error("start no osc");
    a_trigger_first: assert property ((s_trigger and (logEn_r && !lowPend_r)) |=>
        logWr.we && !sampleTick && logWr.data == $past(code[15:8])) else $error("trigger sample");
    a_wide_pair: assert property (logWr_nxt.we && !lowPend_r && logWide_r ##1 1'b1 |=>
        logWr.we && logWr.addr == $past(logWr.addr) + 17'h1) else $error("wide pair");
    a_clk_lock: assert property (locked && wrHit(regReq, ADR_CLK_CTL) |=> $stable(clkCtl_r)) else $error("clock ctl written in mission");
endmodule // tam_mission_cfg

// [hw/tam_pkg.sv]
// shared constants and carriers of the temperature alarm and mission configuration block
package tam_pkg;
    // register byte addresses
    localparam logic [15:0] ADR_LOW_THR  = 16'h0208;
    localparam logic [15:0] ADR_HIGH_THR = 16'h0209;
    localparam logic [15:0] ADR_RES_LO   = 16'h020c;
    localparam logic [15:0] ADR_RES_HI   = 16'h020d;
    localparam logic [15:0] ADR_ALM_EN   = 16'h0210;
    localparam logic [15:0] ADR_CLK_CTL  = 16'h0212;
    localparam logic [15:0] ADR_MIS_CTL  = 16'h0213;
    localparam logic [15:0] ADR_ALM_STAT = 16'h0214;
    localparam logic [15:0] ADR_GEN_STAT = 16'h0215;
    // field positions
    localparam int BIT_HIGH_EN   = 1;
    localparam int BIT_LOW_EN    = 0;
    localparam int BIT_RATE_SEC  = 1;
    localparam int BIT_OSC_EN    = 0;
    localparam int BIT_START_ALM = 5;
    localparam int BIT_MIS_X3    = 3;
    localparam int BIT_WIDE      = 2;
    localparam int BIT_MIS_B1    = 1;
    localparam int BIT_LOG_EN    = 0;
    // reset values
    localparam logic [7:0] RST_THR  = 8'h00;
    localparam logic [1:0] RST_CTL2 = 2'h0;
    // temperature coding: celsius = upper/2 - 41 + lower/512, threshold = 2*celsius + 82
    localparam int TEMP_OFFSET_C   = 41;
    localparam int THR_OFFSET      = 82;
    localparam logic [15:0] CODE_UNDER = 16'h0000;
    localparam logic [15:0] CODE_OVER  = 16'hffe0;
    localparam int RAW_SHIFT       = 5;
    // data log base address and clock
    localparam logic [16:0] LOG_BASE = 17'h01000;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int OSC_STARTUP_US  = 1000;

    // register write request from the serial command logic
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } tam_regreq_s;

    // conversion result from the sensor front end
    typedef struct packed {
        logic        valid;
        logic        under;
        logic        over;
        logic [10:0] raw;
    } tam_conv_s;

    // one byte write into the data log memory
    typedef struct packed {
        logic        we;
        logic [16:0] addr;
        logic [7:0]  data;
    } tam_logwr_s;

    // mission sequencing
    typedef enum logic [1:0] {
        MS_IDLE  = 2'b00,
        MS_DELAY = 2'b01,
        MS_WAIT  = 2'b10,
        MS_RUN   = 2'b11
    } tam_mis_e;
endpackage

// [hw/tam_alarm_cmp.sv]
// threshold comparator on the upper result byte
`timescale 1ns/1ps
module tam_alarm_cmp (
    input  wire logic [7:0] upperByte,
    input  wire logic [7:0] lowThr,
    input  wire logic [7:0] highThr,
    input  wire logic       highEn,
    input  wire logic       lowEn,
    output logic            highHit,
    output logic            lowHit
);
    // only the upper byte is compared, gated by its enable
    always_comb begin
        highHit = highEn && (upperByte >= highThr);
        lowHit  = lowEn && (upperByte <= lowThr);
    end
endmodule // tam_alarm_cmp

// [test/tam_host_model.sv]
// host side model: register writes, register reads and mission commands
`timescale 1ns/1ps
module tam_host_model (
    input  wire logic            clk,
    input  wire logic [7:0]      regRdata,
    output tam_pkg::tam_regreq_s regReq,
    output logic                 startMissionCmd,
    output logic                 stopMissionCmd,
    output logic                 clearMemoryCmd
);
    import tam_pkg::*;

    // idle bus and commands from time zero
    initial begin
        regReq = '0;
        startMissionCmd = 1'b0;
        stopMissionCmd = 1'b0;
        clearMemoryCmd = 1'b0;
    end

    // one byte write, strobe held across one rising edge
    task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a === ADR_MIS_CTL) v[BIT_MIS_B1] = 1'b0;
        @(negedge clk);
        regReq = '{1'b1, a, v};
        @(negedge clk);
        regReq.wr = 1'b0;
    endtask

    // present an address and take the registered read data
    task automatic read_reg(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        regReq.addr = a;
        @(negedge clk);
        @(negedge clk);
        d = regRdata;
    endtask

    // one-cycle command pulse: 0 start, 1 stop, 2 clear memory
    task automatic cmd(input int which);
        @(negedge clk);
        startMissionCmd = (which == 0);
        stopMissionCmd = (which == 1);
        clearMemoryCmd = (which == 2);
        @(negedge clk);
        {startMissionCmd, stopMissionCmd, clearMemoryCmd} = 3'h0;
    endtask
endmodule // tam_host_model

// [test/tam_mission_cfg_tb.sv]
// self-checking bench of the mission configuration block
`timescale 1ns/1ps
module tam_mission_cfg_tb;
    import tam_pkg::*;
    logic                clk;
    logic                rst_b;
    tam_regreq_s         regReq;
    tam_conv_s           conv;
    logic                startMissionCmd, stopMissionCmd, clearMemoryCmd;
    logic                startDelayDone;
    logic [7:0]          regRdata;
    tam_logwr_s          logWr;
    logic                sampleTick, missionRunning, oscillatorEnable, oscRunning, rateUnitSeconds;
    int                  numErrors, checksDone, cycles;
    logic [15:0]         rowAdr [7] = '{16'h0208, 16'h0209, 16'h0210, 16'h0212, 16'h0213, 16'h0214, 16'h0300};
    logic [7:0]          rowDat [7] = '{8'h85, 8'h3e, 8'hff, 8'hff, 8'h00, 8'h55, 8'h55};
    logic [7:0]          rowExp [7] = '{8'h85, 8'h3e, 8'h03, 8'h03, 8'hd0, 8'hf0, 8'h00};

    tam_mission_cfg #(.OSC_STARTUP_US(1)) u_dut (.clk(clk), .rst_b(rst_b), .regReq(regReq), .conv(conv),
        .startMissionCmd(startMissionCmd), .stopMissionCmd(stopMissionCmd), .clearMemoryCmd(clearMemoryCmd),
        .startDelayDone(startDelayDone), .regRdata(regRdata), .logWr(logWr), .sampleTick(sampleTick),
        .missionRunning(missionRunning), .oscillatorEnable(oscillatorEnable), .oscRunning(oscRunning),
        .rateUnitSeconds(rateUnitSeconds));
    tam_host_model u_host (.clk(clk), .regRdata(regRdata), .regReq(regReq), .startMissionCmd(startMissionCmd),
        .stopMissionCmd(stopMissionCmd), .clearMemoryCmd(clearMemoryCmd));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial clk = 1'b0;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            numErrors++;
            $display("wrong value at %0t: run did not finish", $time);
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic stop_test();
        if (numErrors == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // compare one value and count it
    task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string msg);
        checksDone++;
        if (got !== exp) begin
            numErrors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // read a register and compare it
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read_reg(a, d);
        chk({9'h0, d}, {9'h0, exp}, "register read");
    endtask

    // one conversion pulse, then the expected log bytes (n of them) cycle by cycle
    task automatic do_conv(input logic [10:0] raw, input logic un, input logic ov, input logic [16:0] adr,
                           input logic [7:0] d0, input logic [7:0] d1, input logic tick, input int n);
        @(negedge clk);
        conv = '{1'b1, un, ov, raw};
        @(negedge clk);
        conv.valid = 1'b0;
        chk({16'h0, logWr.we}, {16'h0, n > 0}, "first log strobe");
        if (n > 0) begin
            chk(logWr.addr, adr, "first log address");
            chk({9'h0, logWr.data}, {9'h0, d0}, "first log byte");
            chk({16'h0, sampleTick}, {16'h0, tick}, "sample tick");
        end
        @(negedge clk);
        chk({16'h0, logWr.we}, {16'h0, n > 1}, "second log strobe");
        if (n > 1) begin
            chk(logWr.addr, adr + 17'h1, "second log address");
            chk({9'h0, logWr.data}, {9'h0, d1}, "second log byte");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_b = 1'b0;
        conv = '0;
        startDelayDone = 1'b0;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk({14'h0, missionRunning, oscillatorEnable, rateUnitSeconds}, 17'h0, "state after reset");
        // register table: write each row, read it back
        for (int i = 0; i < 7; i++) begin
            u_host.write_reg(rowAdr[i], rowDat[i]);
            rd(rowAdr[i], rowExp[i]);
        end
        // mission one: wide format, both alarms, start delay pending
        u_host.cmd(2);
        u_host.write_reg(ADR_ALM_EN, 8'h03);
        u_host.write_reg(ADR_MIS_CTL, 8'h07);
        u_host.write_reg(ADR_CLK_CTL, 8'h02);
        u_host.write_reg(ADR_LOW_THR, 8'h40);
        u_host.write_reg(ADR_HIGH_THR, 8'h85);
        rd(ADR_MIS_CTL, 8'hd5);
        u_host.cmd(0);
        @(negedge clk);
        chk({14'h0, oscillatorEnable, missionRunning, rateUnitSeconds}, 17'h7, "start state");
        repeat (8) @(negedge clk);
        chk({16'h0, oscRunning}, 17'h0, "oscillator still starting");
        do_conv(11'h42d, 1'b0, 1'b0, 17'h0, 8'h0, 8'h0, 1'b0, 0);
        startDelayDone = 1'b1;
        for (int i = 0; i < 60 && oscRunning !== 1'b1; i++) @(negedge clk);
        chk({16'h0, oscRunning}, 17'h1, "oscillator running");
        do_conv(11'h42d, 1'b0, 1'b0, 17'h01000, 8'h85, 8'ha0, 1'b1, 2);
        do_conv(11'h7ff, 1'b1, 1'b0, 17'h01002, 8'h00, 8'h00, 1'b1, 2);
        do_conv(11'h000, 1'b0, 1'b1, 17'h01004, 8'hff, 8'he0, 1'b1, 2);
        rd(ADR_ALM_STAT, 8'h73);
        rd(ADR_RES_HI, 8'hff);
        rd(ADR_RES_LO, 8'he0);
        u_host.write_reg(ADR_ALM_EN, 8'h00);
        rd(ADR_ALM_EN, 8'h03);
        u_host.write_reg(ADR_CLK_CTL, 8'h00);
        rd(ADR_CLK_CTL, 8'h03);
        // mission two: start on alarm, narrow format, high alarm only
        u_host.cmd(1);
        u_host.cmd(2);
        u_host.write_reg(ADR_ALM_EN, 8'h02);
        u_host.write_reg(ADR_MIS_CTL, 8'h21);
        startDelayDone = 1'b0;
        u_host.cmd(0);
        // an alarming sample during the start delay is ignored
        do_conv(11'h480, 1'b0, 1'b0, 17'h0, 8'h0, 8'h0, 1'b0, 0);
        startDelayDone = 1'b1;
        repeat (3) @(negedge clk);
        do_conv(11'h080, 1'b0, 1'b0, 17'h0, 8'h0, 8'h0, 1'b0, 0);
        rd(ADR_ALM_STAT, 8'h70);
        do_conv(11'h480, 1'b0, 1'b0, 17'h01000, 8'h90, 8'h0, 1'b0, 1);
        rd(ADR_GEN_STAT, 8'hc2);
        do_conv(11'h100, 1'b0, 1'b0, 17'h01001, 8'h20, 8'h0, 1'b1, 1);
        rd(ADR_ALM_STAT, 8'h72);
        // reset in mid-run: back to idle, and a start without clear is refused
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk({14'h0, missionRunning, oscillatorEnable, rateUnitSeconds}, 17'h0, "state after mid-run reset");
        rd(ADR_ALM_STAT, 8'hf0);
        u_host.cmd(0);
        @(negedge clk);
        chk({15'h0, missionRunning, oscillatorEnable}, 17'h0, "start without clear");
        stop_test();
    end
endmodule // tam_mission_cfg_tb
